// ==== src/tc16_pkg.sv ====
// constants, field layout and carrier types of the sixteen-bit timer/counter
// Operation
// - source select clear counts every cycle outside sleep, set counts rising external/crystal edges
// - crystal enable forces both oscillator pins to inputs, ignoring direction bits
// - crystal oscillator keeps running during sleep once enabled
// - sixteen-bit count runs from zero to all ones then wraps to zero
// - wrap latches overflow flag; request raised only when enable bit set
// - special event trigger in compare mode 1011 clears count, starts conversion
// - trigger clear never sets the overflow flag
// - trigger clears count only in timer or synchronised counter mode
// - software count write wins over a trigger in the same cycle
// - wide mode: high address selects buffer, low read snapshots high byte
// - wide mode: high writes go to buffer, low write loads both bytes
// - low byte writes clear the prescaler, high buffer writes do not
// - count bytes unknown at power-on, kept across other resets
// - prescale codes 00..11 divide count clock by 1, 2, 4, 8
// - counting only while run bit set; clearing halts and keeps count
package tc16_pkg;

  // byte addresses of the register words
  localparam logic [7:0] OFS_COUNT_LOW   = 8'h00;
  localparam logic [7:0] OFS_COUNT_HIGH  = 8'h04;
  localparam logic [7:0] OFS_CONTROL     = 8'h08;
  localparam logic [7:0] OFS_IRQ_FLAGS   = 8'h0C;
  localparam logic [7:0] OFS_IRQ_ENABLES = 8'h10;
  localparam logic [7:0] OFS_IRQ_PRIOS   = 8'h14;

  // bit positions in the interrupt registers
  localparam int OVERFLOW_BIT = 0;

  // reset values
  localparam logic [7:0] CONTROL_RST     = 8'h00;
  localparam logic [7:0] IRQ_FLAGS_RST   = 8'h00;
  localparam logic [7:0] IRQ_ENABLES_RST = 8'h00;
  localparam logic [7:0] IRQ_PRIOS_RST   = 8'h00;
  localparam logic [7:0] HIGH_BUF_RST    = 8'h00;

  // compare mode that produces the special event trigger
  localparam logic [3:0] CMP_SPECIAL_EVENT = 4'hB;

  // prescale codes
  localparam logic [1:0] PRE_DIV1 = 2'h0;
  localparam logic [1:0] PRE_DIV2 = 2'h1;
  localparam logic [1:0] PRE_DIV4 = 2'h2;
  localparam logic [1:0] PRE_DIV8 = 2'h3;

  // timer_control layout, bit 7 first
  typedef struct packed {
    logic       wide_access_mode;
    logic       unused6;
    logic [1:0] prescale_select;
    logic       crystal_osc_enable;
    logic       ext_sync_select;
    logic       clock_source_select;
    logic       timer_run;
  } tc16_ctrl_s;

  // compare unit side of the block
  typedef struct packed {
    logic [3:0] compare_mode_select;
    logic       trigger;
    logic       adc_enable;
  } tc16_cmp_s;

endpackage : tc16_pkg

// ==== src/tc16_edge_sync.sv ====
// rising edge finder for one pin, synchronised and direct paths
`timescale 1ns/100ps
`default_nettype none
module tc16_edge_sync #(
  parameter int STAGES = 2
) (
  // clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // pin level
  input  wire logic pin,
  // edge pulses
  output logic      rise_sync,
  output logic      rise_direct
);

  initial begin
    if (STAGES < 2) begin
      $error("tc16_edge_sync needs at least two stages");
    end
  end

  logic [STAGES:0] sync_reg;
  logic            direct_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_reg <= '0;
    end else begin
      sync_reg <= {sync_reg[STAGES-1:0], pin};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      direct_reg <= 1'b0;
    end else begin
      direct_reg <= pin;
    end
  end

  // only the last two stages feed the edge compare
  assign rise_sync   = sync_reg[STAGES-1] & ~sync_reg[STAGES];
  assign rise_direct = pin & ~direct_reg;

endmodule : tc16_edge_sync
`default_nettype wire

// ==== src/tc16_timer.sv ====
// sixteen-bit timer/counter with AHB-Lite register slave
`timescale 1ns/100ps
`default_nettype none
module tc16_timer #(
  parameter int COUNT_W = 16
) (
  // clock and reset
  input  wire logic              hclk,
  input  wire logic              hresetn,
  // AHB-Lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic [31:0]            hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  // pins and port direction
  input  wire logic              ext_clock_pin,
  input  wire logic              osc_in_pin,
  input  wire logic [1:0]        port_direction_reg,
  output logic [1:0]             pin_is_input,
  output logic                   osc_running,
  // device state
  input  wire logic              sleep_mode,
  // compare unit
  input  wire tc16_pkg::tc16_cmp_s cmp,
  output logic                   adc_start,
  // interrupt request and priority
  output logic                   overflow_irq,
  output logic                   overflow_irq_high
);
  import tc16_pkg::*;

  initial begin
    if (COUNT_W != 16) begin
      $error("tc16_timer supports only a sixteen-bit count");
    end
  end

  // registers
  tc16_ctrl_s  ctrl_reg;
  logic [7:0]  flags_reg;
  logic [7:0]  enables_reg;
  logic [7:0]  prios_reg;
  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic [7:0]  high_buf_reg;
  logic [2:0]  pre_reg;
  logic [2:0]  pre_next;

  // bus pipeline
  logic        dp_write_reg;
  logic [7:0]  dp_addr_reg;
  logic        addr_phase;
  logic        rd_phase;
  logic [31:0] rd_value;

  // events
  logic        src_edge;
  logic        src_tick;
  logic        pre_tick;
  logic        wrap;
  logic        trig_ok;
  logic        wr_low;
  logic        wr_high;
  logic        wr_ctrl;
  logic        wr_flags;
  logic        rd_low;
  logic        ext_rise_sync;
  logic        ext_rise_direct;
  logic        osc_rise_sync;
  logic        osc_rise_direct;
  logic [2:0]  pre_limit;

  // edge finders for the two external sources
  tc16_edge_sync #(
    .STAGES (2)
  ) u_ext_edge (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .pin         (ext_clock_pin),
    .rise_sync   (ext_rise_sync),
    .rise_direct (ext_rise_direct)
  );

  tc16_edge_sync #(
    .STAGES (2)
  ) u_osc_edge (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .pin         (osc_in_pin),
    .rise_sync   (osc_rise_sync),
    .rise_direct (osc_rise_direct)
  );

  // bus decode; only whole-word single transfers are expected
  assign addr_phase = hsel & htrans[1] & hready;
  assign rd_phase   = addr_phase & ~hwrite;
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write_reg <= 1'b0;
      dp_addr_reg  <= 8'h00;
    end else begin
      dp_write_reg <= addr_phase & hwrite;
      dp_addr_reg  <= haddr[7:0];
    end
  end

  assign wr_low   = dp_write_reg & (dp_addr_reg == OFS_COUNT_LOW);
  assign wr_high  = dp_write_reg & (dp_addr_reg == OFS_COUNT_HIGH);
  assign wr_ctrl  = dp_write_reg & (dp_addr_reg == OFS_CONTROL);
  assign wr_flags = dp_write_reg & (dp_addr_reg == OFS_IRQ_FLAGS);
  assign rd_low   = rd_phase & (haddr[7:0] == OFS_COUNT_LOW);

  // read mux, captured at the address phase edge
  always_comb begin
    rd_value = 32'h0000_0000;
    case (haddr[7:0])
      OFS_COUNT_LOW: begin
        rd_value[7:0] = count_reg[7:0];
      end
      OFS_COUNT_HIGH: begin
        rd_value[7:0] = ctrl_reg.wide_access_mode ? high_buf_reg
                                                  : count_reg[15:8];
      end
      OFS_CONTROL: begin
        rd_value[7:0] = ctrl_reg;
        rd_value[6]   = 1'b0;
      end
      OFS_IRQ_FLAGS: begin
        rd_value[7:0] = flags_reg;
      end
      OFS_IRQ_ENABLES: begin
        rd_value[7:0] = enables_reg;
      end
      OFS_IRQ_PRIOS: begin
        rd_value[7:0] = prios_reg;
      end
      default: begin
        rd_value = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_phase) begin
      hrdata <= rd_value;
    end
  end

  // control and interrupt registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= CONTROL_RST;
    end else if (wr_ctrl) begin
      ctrl_reg        <= hwdata[7:0];
      ctrl_reg.unused6 <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      enables_reg <= IRQ_ENABLES_RST;
      prios_reg   <= IRQ_PRIOS_RST;
    end else begin
      if (dp_write_reg & (dp_addr_reg == OFS_IRQ_ENABLES)) begin
        enables_reg <= hwdata[7:0];
      end
      if (dp_write_reg & (dp_addr_reg == OFS_IRQ_PRIOS)) begin
        prios_reg <= hwdata[7:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags_reg <= IRQ_FLAGS_RST;
    end else begin
      if (wr_flags) begin
        flags_reg <= hwdata[7:0];
      end
      if (wrap) begin
        flags_reg[OVERFLOW_BIT] <= 1'b1;
      end
    end
  end

  assign overflow_irq      = flags_reg[OVERFLOW_BIT]
                           & enables_reg[OVERFLOW_BIT];
  assign overflow_irq_high = prios_reg[OVERFLOW_BIT];

  assign pin_is_input = ctrl_reg.crystal_osc_enable ? 2'h3
                                                    : port_direction_reg;
  assign osc_running  = ctrl_reg.crystal_osc_enable;

  // count source selection
  always_comb begin
    src_edge = 1'b0;
    if (ctrl_reg.crystal_osc_enable) begin
      src_edge = ctrl_reg.ext_sync_select ? osc_rise_direct
                                          : osc_rise_sync;
    end else begin
      src_edge = ctrl_reg.ext_sync_select ? ext_rise_direct
                                          : ext_rise_sync;
    end
  end

  // instruction cycle or edge
  // the instruction clock stops in sleep; only edges keep counting
  assign src_tick = ctrl_reg.clock_source_select ? src_edge : ~sleep_mode;

  // divide by 1, 2, 4, 8
  always_comb begin
    case (ctrl_reg.prescale_select)
      PRE_DIV1: pre_limit = 3'h0;
      PRE_DIV2: pre_limit = 3'h1;
      PRE_DIV4: pre_limit = 3'h3;
      PRE_DIV8: pre_limit = 3'h7;
      default:  pre_limit = 3'h0;
    endcase
  end

  assign pre_tick = ctrl_reg.timer_run & src_tick & (pre_reg >= pre_limit);

  always_comb begin
    pre_next = pre_reg;
    if (ctrl_reg.timer_run & src_tick) begin
      pre_next = (pre_reg >= pre_limit) ? 3'h0 : pre_reg + 3'h1;
    end
    if (wr_low) begin
      pre_next = 3'h0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_reg <= 3'h0;
    end else begin
      pre_reg <= pre_next;
    end
  end

  // trigger ignored in direct external mode
  assign trig_ok = cmp.trigger
                 & (cmp.compare_mode_select == CMP_SPECIAL_EVENT)
                 & ~(ctrl_reg.clock_source_select
                     & ctrl_reg.ext_sync_select);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      adc_start <= 1'b0;
    end else begin
      adc_start <= cmp.trigger & cmp.adc_enable
                 & (cmp.compare_mode_select == CMP_SPECIAL_EVENT);
    end
  end

  // wrap from all ones; trigger clear excluded
  assign wrap = pre_tick & (count_reg == 16'hFFFF) & ~trig_ok
              & ~wr_low & ~wr_high;

  always_comb begin
    count_next = count_reg;
    if (pre_tick) begin
      count_next = count_reg + 16'h0001;
    end
    if (trig_ok) begin
      count_next = 16'h0000;
    end
    if (wr_high & ~ctrl_reg.wide_access_mode) begin
      count_next = {hwdata[7:0], count_reg[7:0]};
    end
    if (wr_low) begin
      count_next = ctrl_reg.wide_access_mode ? {high_buf_reg, hwdata[7:0]}
                                             : {count_reg[15:8], hwdata[7:0]};
    end
  end

  // no reset: count survives resets, unknown at power-on
  always_ff @(posedge hclk) begin
    count_reg <= count_next;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      high_buf_reg <= HIGH_BUF_RST;
    end else if (wr_high & ctrl_reg.wide_access_mode) begin
      high_buf_reg <= hwdata[7:0];
    end else if (rd_low & ctrl_reg.wide_access_mode) begin
      high_buf_reg <= count_reg[15:8];
    end
  end

endmodule : tc16_timer
`default_nettype wire

// ==== tb/tc16_checker.sv ====
// port assertions for the timer/counter, bound into the top module
`timescale 1ns/100ps
`default_nettype none
module tc16_checker (
  // clock and reset
  input wire logic                hclk,
  input wire logic                hresetn,
  // register bus
  input wire logic                hsel,
  input wire logic [31:0]         haddr,
  input wire logic [1:0]          htrans,
  input wire logic                hwrite,
  input wire logic                hready,
  input wire logic [31:0]         hwdata,
  input wire logic [31:0]         hrdata,
  input wire logic                hreadyout,
  input wire logic                hresp,
  // pins, compare unit, request
  input wire logic [1:0]          port_direction_reg,
  input wire logic [1:0]          pin_is_input,
  input wire logic                osc_running,
  input wire logic                sleep_mode,
  input wire tc16_pkg::tc16_cmp_s cmp,
  input wire logic                adc_start,
  input wire logic                overflow_irq
);
  import tc16_pkg::*;
  logic wr_a;
  logic rd_a;
  logic fire;
  assign wr_a = hsel && htrans[1] && hwrite && hready;
  assign rd_a = hsel && htrans[1] && !hwrite && hready;
  assign fire = cmp.trigger && cmp.adc_enable
                && cmp.compare_mode_select == CMP_SPECIAL_EVENT;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  a_pins_input: assert property (
    osc_running |-> pin_is_input == 2'h3) else $error("pins not inputs");
  a_pins_follow: assert property (
    !osc_running |-> pin_is_input == port_direction_reg)
    else $error("pins ignore direction");
  // a control write is the only thing that may stop the crystal
  a_osc_sleep: assert property (
    sleep_mode && osc_running && !$past(wr_a) |=> osc_running)
    else $error("crystal stopped in sleep");
  a_adc_pulse: assert property (
    fire |=> adc_start) else $error("no conversion start");
  a_adc_cause: assert property (
    adc_start |-> $past(fire)) else $error("stray conversion start");
  a_irq_masked: assert property (
    $past(wr_a && haddr[7:0] == OFS_IRQ_ENABLES) && !hwdata[0]
    |=> !overflow_irq) else $error("masked request raised");
  a_unmapped_zero: assert property (
    rd_a && haddr[7:0] > OFS_IRQ_PRIOS |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_bus_okay: assert property (
    hreadyout && !hresp) else $error("bus not ready or error");
endmodule : tc16_checker

bind tc16_timer tc16_checker tc16_checker_inst (.hclk, .hresetn, .hsel,
  .haddr, .htrans, .hwrite, .hready, .hwdata, .hrdata, .hreadyout, .hresp,
  .port_direction_reg, .pin_is_input, .osc_running, .sleep_mode, .cmp,
  .adc_start, .overflow_irq);
`default_nettype wire

// ==== tb/tc16_clk_src.sv ====
// behavioural external count clock and crystal oscillator
`timescale 1ns/100ps
`default_nettype none
module tc16_clk_src (
  // which pin the edges go to, 1 for the crystal input
  input wire logic sel_osc,
  // clock pins
  output var logic ext_clock_pin,
  output var logic osc_in_pin
);
  initial begin
    ext_clock_pin = 1'b0;
    osc_in_pin = 1'b0;
  end
  // lines rest low between bursts, so no stray edge is counted
  task automatic burst(input int n, input int half);
    // step off the clock edge so no pin change races the sampling edge
    #1;
    for (int i = 0; i < n; i++) begin
      #(half);
      if (sel_osc) osc_in_pin = 1'b1;
      else ext_clock_pin = 1'b1;
      #(half);
      osc_in_pin = 1'b0;
      ext_clock_pin = 1'b0;
    end
  endtask : burst
endmodule : tc16_clk_src
`default_nettype wire

// ==== tb/tc16_timer_bench.sv ====
// self-checking bench for the sixteen-bit timer/counter
`timescale 1ns/100ps
`default_nettype none
module tc16_timer_bench;
  import tc16_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans, port_direction_reg, pin_is_input;
  logic        ext_clock_pin, osc_in_pin, osc_running, sleep_mode;
  logic        adc_start, overflow_irq, overflow_irq_high, sel_osc;
  tc16_cmp_s   cmp;
  logic [7:0]  q;
  logic [7:0]  regs [4];
  int          error_cnt, total_checks;

  tc16_timer tc16_timer_inst (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
    .hresp, .ext_clock_pin, .osc_in_pin, .port_direction_reg, .pin_is_input,
    .osc_running, .sleep_mode, .cmp, .adc_start, .overflow_irq,
    .overflow_irq_high);
  tc16_clk_src tc16_clk_src_inst (.sel_osc, .ext_clock_pin, .osc_in_pin);

  always #5 hclk = ~hclk;

  task automatic print_verdict;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wait_ready;
    int n = 0;
    while (hreadyout !== 1'b1) begin
      if (++n > 20) begin
        error_cnt++;
        print_verdict();
      end
      @(posedge hclk);
    end
  endtask : wait_ready

  // one single transfer; t raises the trigger in the data phase
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [7:0] d, input logic t);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    @(posedge hclk);
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    cmp.trigger <= t;
    @(posedge hclk);
    wait_ready();
    q = hrdata[7:0];
    cmp.trigger <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 1'b0);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00, 1'b0);
    chk(q, e);
  endtask : rd

  // edges then time for the synchroniser to settle
  task automatic edges(input int n, input int half);
    tc16_clk_src_inst.burst(n, half);
    repeat (4) @(posedge hclk);
  endtask : edges

  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = '0;
    sleep_mode = 1'b0;
    sel_osc = 1'b0;
    port_direction_reg = 2'h1;
    cmp = '0;
    cmp.compare_mode_select = CMP_SPECIAL_EVENT;
    cmp.adc_enable = 1'b1;
    regs = '{OFS_CONTROL, OFS_IRQ_FLAGS, OFS_IRQ_ENABLES, OFS_IRQ_PRIOS};
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (regs[i]) rd(regs[i], 8'h00);
    rd(8'h40, 8'h00);
    wr(OFS_IRQ_ENABLES, 8'h01);
    wr(OFS_CONTROL, 8'h02);
    wr(OFS_COUNT_LOW, 8'hFF);
    wr(OFS_COUNT_HIGH, 8'hFF);
    edges(3, 25);
    rd(OFS_COUNT_LOW, 8'hFF);
    wr(OFS_CONTROL, 8'h03);
    edges(1, 25);
    rd(OFS_COUNT_LOW, 8'h00);
    rd(OFS_COUNT_HIGH, 8'h00);
    rd(OFS_IRQ_FLAGS, 8'h01);
    chk({7'h0, overflow_irq}, 8'h01);
    wr(OFS_IRQ_FLAGS, 8'h00);
    rd(OFS_IRQ_FLAGS, 8'h00);
    wr(OFS_IRQ_FLAGS, 8'h01);
    rd(OFS_IRQ_FLAGS, 8'h01);
    wr(OFS_IRQ_ENABLES, 8'h00);
    wr(OFS_IRQ_PRIOS, 8'h01);
    chk({7'h0, overflow_irq}, 8'h00);
    rd(OFS_IRQ_PRIOS, 8'h01);
    chk({7'h0, overflow_irq_high}, 8'h01);
    wr(OFS_IRQ_FLAGS, 8'h00);
    for (int p = 0; p < 4; p++) begin
      wr(OFS_CONTROL, {2'h0, p[1:0], 4'h3});
      wr(OFS_COUNT_HIGH, 8'h00);
      wr(OFS_COUNT_LOW, 8'h00);
      edges(8, 15);
      rd(OFS_COUNT_LOW, 8'h08 >> p);
    end
    wr(OFS_CONTROL, 8'h13);
    wr(OFS_COUNT_LOW, 8'h00);
    edges(1, 25);
    wr(OFS_COUNT_HIGH, 8'h00);
    edges(1, 25);
    rd(OFS_COUNT_LOW, 8'h01);
    wr(OFS_CONTROL, 8'h03);
    wr(OFS_COUNT_LOW, 8'h34);
    bus(1'b0, OFS_IRQ_PRIOS, 8'h00, 1'b1);
    rd(OFS_COUNT_LOW, 8'h00);
    rd(OFS_IRQ_FLAGS, 8'h00);
    bus(1'b1, OFS_COUNT_LOW, 8'h56, 1'b1);
    rd(OFS_COUNT_LOW, 8'h56);
    wr(OFS_CONTROL, 8'h07);
    bus(1'b0, OFS_IRQ_PRIOS, 8'h00, 1'b1);
    rd(OFS_COUNT_LOW, 8'h56);
    wr(OFS_CONTROL, 8'h82);
    wr(OFS_COUNT_HIGH, 8'hAB);
    rd(OFS_COUNT_LOW, 8'h56);
    rd(OFS_COUNT_HIGH, 8'h00);
    wr(OFS_COUNT_HIGH, 8'hAB);
    wr(OFS_COUNT_LOW, 8'hCD);
    rd(OFS_COUNT_LOW, 8'hCD);
    rd(OFS_COUNT_HIGH, 8'hAB);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rd(OFS_COUNT_LOW, 8'hCD);
    rd(OFS_COUNT_HIGH, 8'hAB);
    wr(OFS_CONTROL, 8'h0B);
    // start-up delay before the crystal is trusted
    repeat (20) @(posedge hclk);
    chk({6'h0, pin_is_input}, 8'h03);
    sleep_mode <= 1'b1;
    sel_osc = 1'b1;
    wr(OFS_COUNT_LOW, 8'h00);
    edges(2, 25);
    chk({7'h0, osc_running}, 8'h01);
    rd(OFS_COUNT_LOW, 8'h02);
    wr(OFS_CONTROL, 8'h00);
    sleep_mode <= 1'b0;
    rd(OFS_CONTROL, 8'h00);
    chk({6'h0, pin_is_input}, 8'h01);
    // internal source: run lands at one data edge, stop at the third after
    wr(OFS_COUNT_HIGH, 8'h00);
    wr(OFS_COUNT_LOW, 8'h00);
    wr(OFS_CONTROL, 8'h01);
    wr(OFS_CONTROL, 8'h00);
    rd(OFS_COUNT_LOW, 8'h03);
    rd(OFS_COUNT_HIGH, 8'h00);
    print_verdict();
  end
endmodule : tc16_timer_bench
`default_nettype wire
